// ==== hbs_cpu_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// Behavioural processor that reads its address straps as its reset ends.
module hbs_cpu_model (
    // Clock and CPU reset.
    input wire logic pclk,
    input wire logic cpu_reset_n,
    // Address strap lines from the bridge.
    input wire logic q_out_n,
    input wire logic q_oe,
    input wire logic s_out_n,
    input wire logic s_oe,
    // Configuration taken at the reset rise.
    output logic [3:0] queue_depth,
    output logic quick_start
);
    logic q_level;
    logic s_level;
    logic cpu_reset_q;
    // Bus termination pulls each line high whenever the bridge lets go.
    assign q_level = q_oe ? q_out_n : 1'b1;
    assign s_level = s_oe ? s_out_n : 1'b1;
    // Both lines are read at the first edge that sees CPU reset released.
    always_ff @(posedge pclk) begin
        cpu_reset_q <= cpu_reset_n;
        if (!cpu_reset_n) begin
            queue_depth <= 4'h0;
            quick_start <= 1'b0;
        end else if (!cpu_reset_q) begin
            queue_depth <= q_level ? 4'h8 : 4'h1;
            quick_start <= !s_level;
        end
    end
endmodule // hbs_cpu_model
`default_nettype wire

// ==== hbs_pkg.sv ====
`default_nettype none
// Shared constants of the host bridge reset strap loader.
package hbs_pkg;
    // Clock and timing.
    localparam int CLK_PERIOD_NS = 10;
    localparam int CPU_RST_HOLD_NS = 1000;
    localparam int CPU_RST_HOLD_CYC = (CPU_RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DELAYED_CPU_RESET_DELAY_CYC = 2;
    // Bus widths.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // Register byte offsets.
    localparam logic [7:0] OFS_STRAP_STATUS = 8'h00;
    localparam logic [7:0] OFS_BRIDGE_CONFIG = 8'h04;
    localparam logic [7:0] OFS_SDRAM_CONTROL = 8'h08;
    // Strap positions in the captured strap vector.
    localparam int NUM_STRAPS = 6;
    localparam int S_BUFFER = 0;
    localparam int S_MEMCOMPAT = 1;
    localparam int S_GFXOFF = 2;
    localparam int S_QSTART = 3;
    localparam int S_QDEPTH = 4;
    localparam int S_FREQ = 5;
    // Internal pull values seen when a strap is left undriven.
    localparam logic [5:0] STRAP_PULLS = 6'h10;
    // Field positions.
    localparam int STATUS_VALID_BIT = 8;
    localparam int STATUS_CPU_RESET_BIT = 9;
    localparam int REDIRECT_BIT = 16;
    localparam int SDRAM_PWR_BIT = 0;
    // Reset values of the writable registers.
    localparam logic REDIRECT_RST = 1'b0;
    localparam logic SDRAM_PWR_RST = 1'b0;
    // Sequencer states.
    typedef enum logic [1:0] {
        HBS_PCI_RESET,
        HBS_CPU_HOLD,
        HBS_RUN
    } hbs_state_e;
endpackage : hbs_pkg
`default_nettype wire

// ==== hbs_reset_straps.sv ====
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/10ps
`default_nettype none
// Function
// - Frequency strap picks 66 or 100 MHz.
// - Undriven frequency strap defaults to 66 MHz.
// - Queue strap 0 drives address 7 low.
// - Queue strap 1 leaves address 7 undriven.
// - Quick start strap 1 drives address 15 low.
// - Quick start strap 0 leaves address 15 undriven.
// - Graphics strap 1 isolates graphics port.
// - Compat strap isolates unused DRAM signals.
// - Clock enables follow power bit and compat.
// - Delayed CPU reset lags two clocks.
// - PCI reset resets logic, tri-states outputs.
module hbs_reset_straps #(
    parameter int HOLD_CYC = hbs_pkg::CPU_RST_HOLD_CYC
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic [hbs_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [hbs_pkg::DATA_W-1:0] pwdata,
    output logic pready,
    output logic [hbs_pkg::DATA_W-1:0] prdata,
    output logic pslverr,
    // Reset pins.
    input wire logic pci_bus_reset_n,
    output logic cpu_reset_n,
    output logic delayed_cpu_reset_n,
    // Strap pins and whether the board drives each one.
    input wire logic host_freq_strap,
    input wire logic queue_depth_strap,
    input wire logic quick_start_strap,
    input wire logic graphics_port_off_strap,
    input wire logic memory_compat_strap,
    input wire logic buffer_mode_strap,
    input wire logic [hbs_pkg::NUM_STRAPS-1:0] strap_driven,
    // Processor address straps, open drain.
    output logic queue_depth_addr_line_n_out,
    output logic queue_depth_addr_line_oe,
    output logic quick_start_addr_line_n_out,
    output logic quick_start_addr_line_oe,
    // Configuration results.
    output logic host_freq_100,
    output logic mobile_buffers,
    output logic graphics_port_off,
    output logic memory_compat_mode,
    output logic config_select_redirect,
    output logic sdram_cke_dynamic,
    // Output enables of isolated pin groups.
    output logic pci_out_oe,
    output logic graphics_port_oe,
    output logic row_select_set_b_oe,
    output logic mem_addr_set_a_oe,
    output logic sdram_clock_out_oe,
    output logic cke_high_oe
);
    import hbs_pkg::*;

    // Picks the board level or, when undriven, the internal pull.
    function automatic logic resolve(input logic val, input logic drv, input logic pull);
        resolve = drv ? val : pull;
    endfunction

    hbs_state_e state;
    hbs_state_e next_state;
    logic [15:0] hold_cnt;
    logic pci_prev;
    logic pci_rise;
    logic strap_valid;
    logic [NUM_STRAPS-1:0] cap_straps;
    logic [NUM_STRAPS-1:0] pin_straps;
    logic delayed_cpu_reset_d1;
    logic redirect;
    logic sdram_power_bit;
    logic apb_setup;
    logic apb_write;
    logic addr_ok;
    logic [DATA_W-1:0] rd_word;

    // Strap pins with pulls applied.
    always_comb begin
        pin_straps[S_FREQ] = resolve(host_freq_strap, strap_driven[S_FREQ],
                                     STRAP_PULLS[S_FREQ]);
        pin_straps[S_QDEPTH] = resolve(queue_depth_strap, strap_driven[S_QDEPTH],
                                       STRAP_PULLS[S_QDEPTH]);
        pin_straps[S_QSTART] = resolve(quick_start_strap, strap_driven[S_QSTART],
                                       STRAP_PULLS[S_QSTART]);
        pin_straps[S_GFXOFF] = resolve(graphics_port_off_strap, strap_driven[S_GFXOFF],
                                       STRAP_PULLS[S_GFXOFF]);
        pin_straps[S_MEMCOMPAT] = resolve(memory_compat_strap, strap_driven[S_MEMCOMPAT],
                                          STRAP_PULLS[S_MEMCOMPAT]);
        pin_straps[S_BUFFER] = resolve(buffer_mode_strap, strap_driven[S_BUFFER],
                                       STRAP_PULLS[S_BUFFER]);
    end

    assign pci_rise = pci_bus_reset_n & ~pci_prev;

    // Remembers the PCI reset level to find its rising edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pci_prev <= 1'b0;
        end else begin
            pci_prev <= pci_bus_reset_n;
        end
    end

    // Latches the straps once per PCI reset release and keeps them.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_straps <= STRAP_PULLS;
            strap_valid <= 1'b0;
        end else if (pci_rise) begin
            cap_straps <= pin_straps;
            strap_valid <= 1'b1;
        end else if (!pci_bus_reset_n) begin
            strap_valid <= 1'b0;
        end
    end

    // Chooses the next reset sequencer state.
    always_comb begin
        next_state = state;
        case (state)
            HBS_PCI_RESET: begin
                if (pci_rise) begin
                    next_state = HBS_CPU_HOLD;
                end
            end
            HBS_CPU_HOLD: begin
                if (hold_cnt == 16'(HOLD_CYC - 1)) begin
                    next_state = HBS_RUN;
                end
            end
            HBS_RUN: begin
                next_state = HBS_RUN;
            end
            default: begin
                next_state = HBS_PCI_RESET;
            end
        endcase
        if (!pci_bus_reset_n) begin
            next_state = HBS_PCI_RESET;
        end
    end

    // Holds the processor in reset for a while after the straps settle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= HBS_PCI_RESET;
            hold_cnt <= '0;
            cpu_reset_n <= 1'b0;
        end else begin
            state <= next_state;
            hold_cnt <= (state == HBS_CPU_HOLD) ? hold_cnt + 16'h0001 : 16'h0000;
            cpu_reset_n <= (next_state == HBS_RUN);
        end
    end

    // Delayed copy of the CPU reset, two clocks behind.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            delayed_cpu_reset_d1 <= 1'b0;
            delayed_cpu_reset_n <= 1'b0;
        end else begin
            delayed_cpu_reset_d1 <= cpu_reset_n;
            delayed_cpu_reset_n <= delayed_cpu_reset_d1;
        end
    end

    // Drives the processor address straps while the delayed reset is low.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            queue_depth_addr_line_oe <= 1'b0;
            quick_start_addr_line_oe <= 1'b0;
            queue_depth_addr_line_n_out <= 1'b1;
            quick_start_addr_line_n_out <= 1'b1;
        end else begin
            queue_depth_addr_line_oe <= strap_valid & ~delayed_cpu_reset_d1
                                        & ~cap_straps[S_QDEPTH];
            quick_start_addr_line_oe <= strap_valid & ~delayed_cpu_reset_d1
                                        & cap_straps[S_QSTART];
            queue_depth_addr_line_n_out <= 1'b0;
            quick_start_addr_line_n_out <= 1'b0;
        end
    end

    // Turns captured straps into configuration and pin enables.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_freq_100 <= 1'b0;
            mobile_buffers <= 1'b0;
            graphics_port_off <= 1'b0;
            memory_compat_mode <= 1'b0;
            config_select_redirect <= 1'b0;
            sdram_cke_dynamic <= 1'b0;
            pci_out_oe <= 1'b0;
            graphics_port_oe <= 1'b0;
            row_select_set_b_oe <= 1'b0;
            mem_addr_set_a_oe <= 1'b0;
            sdram_clock_out_oe <= 1'b0;
            cke_high_oe <= 1'b0;
        end else begin
            host_freq_100 <= cap_straps[S_FREQ];
            mobile_buffers <= cap_straps[S_BUFFER];
            graphics_port_off <= cap_straps[S_GFXOFF];
            memory_compat_mode <= cap_straps[S_MEMCOMPAT];
            config_select_redirect <= redirect & cap_straps[S_MEMCOMPAT];
            sdram_cke_dynamic <= sdram_power_bit & ~cap_straps[S_MEMCOMPAT];
            pci_out_oe <= pci_bus_reset_n;
            graphics_port_oe <= pci_bus_reset_n & ~cap_straps[S_GFXOFF];
            row_select_set_b_oe <= pci_bus_reset_n & ~cap_straps[S_MEMCOMPAT];
            mem_addr_set_a_oe <= pci_bus_reset_n & ~cap_straps[S_MEMCOMPAT];
            sdram_clock_out_oe <= pci_bus_reset_n & ~cap_straps[S_MEMCOMPAT];
            cke_high_oe <= pci_bus_reset_n & ~cap_straps[S_MEMCOMPAT];
        end
    end

    assign apb_setup = psel & ~penable;
    assign apb_write = psel & penable & pready & pwrite;
    assign addr_ok = (paddr == OFS_STRAP_STATUS) || (paddr == OFS_BRIDGE_CONFIG)
                     || (paddr == OFS_SDRAM_CONTROL);

    // Read multiplexer.
    always_comb begin
        rd_word = '0;
        case (paddr)
            OFS_STRAP_STATUS: begin
                rd_word[NUM_STRAPS-1:0] = cap_straps;
                rd_word[STATUS_VALID_BIT] = strap_valid;
                rd_word[STATUS_CPU_RESET_BIT] = cpu_reset_n;
            end
            OFS_BRIDGE_CONFIG: begin
                rd_word[REDIRECT_BIT] = redirect;
            end
            OFS_SDRAM_CONTROL: begin
                rd_word[SDRAM_PWR_BIT] = sdram_power_bit;
            end
            default: begin
                rd_word = '0;
            end
        endcase
    end

    // Answers every transfer in its first access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            pready <= apb_setup;
            prdata <= (apb_setup && !pwrite) ? rd_word : '0;
            pslverr <= apb_setup & ~addr_ok;
        end
    end

    // Writable control bits, also cleared by PCI reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            redirect <= REDIRECT_RST;
            sdram_power_bit <= SDRAM_PWR_RST;
        end else if (!pci_bus_reset_n) begin
            redirect <= REDIRECT_RST;
            sdram_power_bit <= SDRAM_PWR_RST;
        end else if (apb_write && paddr == OFS_BRIDGE_CONFIG) begin
            redirect <= pwdata[REDIRECT_BIT];
        end else if (apb_write && paddr == OFS_SDRAM_CONTROL) begin
            sdram_power_bit <= pwdata[SDRAM_PWR_BIT];
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Checks of the reset sequence and strap effects.
    a_delayed_cpu_reset_two_clocks: assert property (
        ##2 delayed_cpu_reset_n == $past(cpu_reset_n, 2))
        else $error("delayed cpu reset does not lag by two clocks");
    a_qd_pulls_low: assert property (
        queue_depth_addr_line_oe |-> !queue_depth_addr_line_n_out && !cap_straps[S_QDEPTH])
        else $error("queue depth line driven wrongly");
    a_qs_pulls_low: assert property (
        quick_start_addr_line_oe |-> !quick_start_addr_line_n_out && cap_straps[S_QSTART])
        else $error("quick start line driven wrongly");
    a_qd_window: assert property (
        $rose(cpu_reset_n) && !cap_straps[S_QDEPTH]
        |-> queue_depth_addr_line_oe [*2] ##1 !queue_depth_addr_line_oe)
        else $error("queue depth line not held through deassertion");
    a_addr_release: assert property (
        delayed_cpu_reset_n |-> !queue_depth_addr_line_oe && !quick_start_addr_line_oe)
        else $error("address strap still driven after window");
    a_cpu_hold_len: assert property (
        $rose(cpu_reset_n) |-> $past(hold_cnt) == 16'(HOLD_CYC - 1))
        else $error("cpu reset released after wrong hold");
    a_pci_tristate: assert property (
        !pci_bus_reset_n |=> !pci_out_oe && !graphics_port_oe && !cpu_reset_n)
        else $error("outputs enabled during pci reset");
    a_freq_pulldown: assert property (
        pci_rise && !strap_driven[S_FREQ] |=> !cap_straps[S_FREQ] ##1 !host_freq_100)
        else $error("undriven frequency strap not 66 MHz");
    a_gfx_isolated: assert property (
        graphics_port_off |-> !graphics_port_oe)
        else $error("graphics port enabled while disabled");
    a_compat_isolate: assert property (
        memory_compat_mode |-> !row_select_set_b_oe && !mem_addr_set_a_oe
                               && !sdram_clock_out_oe && !cke_high_oe)
        else $error("dram pins driven in compatibility mode");
    a_redirect_gate: assert property (
        config_select_redirect |-> memory_compat_mode)
        else $error("redirect active without compatibility mode");
    a_straps_held: assert property (
        strap_valid && $past(strap_valid) |-> $stable(cap_straps))
        else $error("captured straps changed while held");
    a_apb_answer: assert property (
        psel && !penable |=> pready ##1 !pready)
        else $error("apb answer not in first access cycle");

    // Main scenarios.
    c_qd_drive: cover property ($rose(queue_depth_addr_line_oe));
    c_qs_drive: cover property ($rose(quick_start_addr_line_oe));
    c_compat: cover property ($rose(memory_compat_mode));
    c_apb_write: cover property (apb_write && paddr == OFS_BRIDGE_CONFIG);
endmodule // hbs_reset_straps
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
// Self-checking bench for the reset strap loader.
module tb_top;
    import hbs_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pci_bus_reset_n = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd;
    logic [5:0] straps = 6'h00, drv = 6'h00;
    wire logic pready, pslverr, cpu_reset_n, dly_n, qn, qoe, sn, soe, freq, mob, gfx, cmp, redir;
    wire logic cke, pci_oe, gfx_oe, rsb_oe, maa_oe, dclk_oe, ckeh_oe, qs;
    wire logic [31:0] prdata;
    wire logic [3:0] qd;
    integer miscompares = 0, checked = 0, seed = 32'h054f9e12, i, n;
    logic [5:0] e;
    hbs_reset_straps #(.HOLD_CYC(4)) u_hbs_reset_straps (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .pci_bus_reset_n(pci_bus_reset_n),
        .cpu_reset_n(cpu_reset_n), .delayed_cpu_reset_n(dly_n), .host_freq_strap(straps[5]),
        .queue_depth_strap(straps[4]), .quick_start_strap(straps[3]),
        .graphics_port_off_strap(straps[2]), .memory_compat_strap(straps[1]),
        .buffer_mode_strap(straps[0]), .strap_driven(drv), .queue_depth_addr_line_n_out(qn),
        .queue_depth_addr_line_oe(qoe), .quick_start_addr_line_n_out(sn),
        .quick_start_addr_line_oe(soe), .host_freq_100(freq), .mobile_buffers(mob),
        .graphics_port_off(gfx), .memory_compat_mode(cmp), .config_select_redirect(redir),
        .sdram_cke_dynamic(cke), .pci_out_oe(pci_oe), .graphics_port_oe(gfx_oe),
        .row_select_set_b_oe(rsb_oe), .mem_addr_set_a_oe(maa_oe),
        .sdram_clock_out_oe(dclk_oe), .cke_high_oe(ckeh_oe));
    hbs_cpu_model u_hbs_cpu_model (.pclk(pclk), .cpu_reset_n(cpu_reset_n), .q_out_n(qn),
        .q_oe(qoe), .s_out_n(sn), .s_oe(soe), .queue_depth(qd), .quick_start(qs));
    // Free-running 100 MHz clock.
    always #5 pclk = ~pclk;
    // Effective strap levels once the internal pulls fill undriven pins.
    function automatic logic [5:0] eff(input logic [5:0] s, input logic [5:0] d);
        return (s & d) | (STRAP_PULLS & ~d);
    endfunction
    // Prints the verdict and stops the run.
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; the request is held until pready is seen high.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic exp_err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            miscompares++;
            end_sim;
        end
        rd = prdata;
        chk(pslverr, exp_err);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Pulses the PCI reset with the given straps and waits for the CPU straps to end.
    task automatic boot(input logic [5:0] s, input logic [5:0] d);
        // The board straps the graphics port off whenever compatibility mode is on.
        e = eff(s, d);
        if (e[S_MEMCOMPAT]) begin
            s[S_GFXOFF] = 1'b1;
            d[S_GFXOFF] = 1'b1;
        end
        @(posedge pclk);
        pci_bus_reset_n <= 1'b0;
        repeat (4) @(posedge pclk);
        #1 chk({pci_oe, gfx_oe, rsb_oe, cpu_reset_n, redir}, 5'h00);
        @(posedge pclk);
        straps <= s;
        drv <= d;
        @(posedge pclk);
        pci_bus_reset_n <= 1'b1;
        e = eff(s, d);
        n = 0;
        i = 0;
        while (dly_n !== 1'b1 && n < 300) begin
            @(posedge pclk);
            #1 n++;
            if (cpu_reset_n === 1'b1 && dly_n !== 1'b1) i++;
        end
        if (dly_n !== 1'b1) begin
            miscompares++;
            end_sim;
        end
        chk(i, 2);
        chk({qoe, soe}, 2'b00);
        chk(qd, e[S_QDEPTH] ? 4'h8 : 4'h1);
        chk(qs, e[S_QSTART]);
        @(posedge pclk);
        straps <= ~s;
        repeat (3) @(posedge pclk);
        chk({freq, mob}, {e[S_FREQ], e[S_BUFFER]});
        chk({gfx, gfx_oe}, {e[S_GFXOFF], !e[S_GFXOFF]});
        chk({cmp, rsb_oe, maa_oe, dclk_oe, ckeh_oe},
            {e[S_MEMCOMPAT], {4{!e[S_MEMCOMPAT]}}});
        chk(pci_oe, 1'b1);
        apb(1'b0, OFS_STRAP_STATUS, 32'h0, 1'b0);
        chk(rd, {22'h0, 2'b11, 2'b00, e});
        // Firmware sets the redirect bit only with compatibility mode on.
        apb(1'b1, OFS_BRIDGE_CONFIG,
            ($random(seed) & 32'hFFFE_FFFF) | (32'(e[S_MEMCOMPAT]) << REDIRECT_BIT),
            1'b0);
        apb(1'b0, OFS_BRIDGE_CONFIG, 32'h0, 1'b0);
        chk(rd, 32'(e[S_MEMCOMPAT]) << REDIRECT_BIT);
        apb(1'b1, OFS_SDRAM_CONTROL, 32'h1, 1'b0);
        repeat (2) @(posedge pclk);
        chk(redir, e[S_MEMCOMPAT]);
        chk(cke, !e[S_MEMCOMPAT]);
        apb(1'b0, 8'h0C, 32'h0, 1'b1);
        chk(rd, 32'h0);
    endtask
    // Main sequence: corner strap sets first, then random ones.
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        boot(6'h00, 6'h00);
        $display("test pulls done");
        boot(6'h3F, 6'h3F);
        $display("test all ones done");
        boot(6'h00, 6'h3F);
        $display("test all zeros done");
        repeat (8) begin
            boot(6'($random(seed)), 6'($random(seed)));
            $display("test random done");
        end
        end_sim;
    end
endmodule // tb_top
`default_nettype wire
